// ### logic/seq_defines.svh
/*
 * Timing constants for the core state sequencer.
 * Assumes inclusion by bare name from the design file; definitions only.
 */
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH

`define SEQ_MIN_STATES      6'h02
`define SEQ_MAX_STATES      6'h30
`define SEQ_MAX_INSTR_BYTES 3'h6
`define SEQ_MAX_SHORT_BYTES 3'h4
`define SEQ_MAX_FIELD_BYTES 2'h3
`define SEQ_EXT_FETCH_EXTRA 2'h1
`define SEQ_IRQ_CYCLES      5'h0e
`define SEQ_IRQ_CYCLES_EXT  5'h11
`define SEQ_IRQ_CLEAR_CYCLE 5'h03

`endif

// ### logic/seq_pkg.sv
/*
 * Types for the core state sequencer.
 * Assumes seq_defines.svh supplies the numeric constants.
 */
`default_nettype none

package seq_pkg;

    // --------------------------------------------------------------
    // Instruction descriptor handed in by the decoder front end
    // --------------------------------------------------------------
    typedef struct packed {
        logic       prefixed;     // prefixed_instruction when set
        logic [1:0] addr_bytes;   // Address field length (prefixed)
        logic [1:0] op_bytes;     // Operation field length (prefixed)
        logic [2:0] short_bytes;  // Length of a short_form_instruction
        logic       assigned;     // Code area holds an instruction
        logic [5:0] exec_states;  // Execution states after fetch
    } instr_desc_s;

    typedef enum logic [2:0] {
        IDLE,
        FETCH,
        FETCH_WAIT,
        EXECUTE,
        IRQ_ENTRY,
        TRAP
    } seq_state_e;

endpackage : seq_pkg

`default_nettype wire

// ### logic/core_state_timing_sequencer.sv
/*
 * Core state timing sequencer: doubles the oscillator rate into the
 * master state clock, sequences fetch/execute in whole states, adds
 * external fetch states, and runs the interrupt entry sequence.
 * Assumes a decoder front end supplies one descriptor per instruction
 * and that the oscillator input is synchronous to clock_i, slower than
 * a quarter of it.
 */
// Operation
// RULE1: Master clock is oscillator frequency doubled
// RULE2: One master clock equals one state
// RULE3: Instruction takes 2 to 48 states
// RULE4: Instructions are one to six bytes
// RULE5: Short-form instructions are one to four bytes
// RULE6: Prefixed: 1-3 address plus 1-3 operation bytes
// RULE7: Trap on unassigned or invalid codes
// RULE8: External fetch adds one state per byte
// RULE9: External fetch adds 0-3 wait states
// RULE10: Interrupt entry lasts 14 cycles
// RULE11: Extended 128K space makes entry 17 cycles
// RULE12: Request flag cleared in third entry cycle
// RULE13: Handler fetch waits for entry to finish
`timescale 1ns/1ns
`default_nettype none
`include "seq_defines.svh"

module core_state_timing_sequencer (
    input  wire logic               clock_i,
    input  wire logic               reset_i,
    input  wire logic               enable_i,
    input  wire logic               osc_i,
    input  wire logic               external_program_select_pin_n_i,
    input  wire logic [1:0]         program_fetch_wait_setting_i,
    input  wire logic               extended_space_i,
    input  wire logic               irq_request_i,
    input  wire logic               instr_valid_i,
    input  wire seq_pkg::instr_desc_s instr_i,
    output logic                    master_clock_o,
    output logic                    state_tick_o,
    output logic                    instr_take_o,
    output logic                    fetch_active_o,
    output logic                    instr_done_o,
    output logic                    opcode_trap_o,
    output logic                    irq_clear_o,
    output logic                    irq_entry_o,
    output logic                    handler_start_o,
    output logic [5:0]              state_count_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] instr_length(input seq_pkg::instr_desc_s d);
        instr_length = d.prefixed ? ({1'b0, d.addr_bytes} + {1'b0, d.op_bytes})
                                  : d.short_bytes;
    endfunction : instr_length

    function automatic logic desc_legal(input seq_pkg::instr_desc_s d);
        logic short_ok;
        logic pre_ok;
        short_ok = (d.short_bytes != 3'h0) && (d.short_bytes <= `SEQ_MAX_SHORT_BYTES); // [RULE5]
        pre_ok   = (d.addr_bytes != 2'h0) && (d.addr_bytes <= `SEQ_MAX_FIELD_BYTES)
                && (d.op_bytes != 2'h0) && (d.op_bytes <= `SEQ_MAX_FIELD_BYTES);      // [RULE6]
        desc_legal = d.assigned
                  && (d.prefixed ? pre_ok : short_ok)
                  && (instr_length(d) <= `SEQ_MAX_INSTR_BYTES)                        // [RULE4]
                  && (d.exec_states >= `SEQ_MIN_STATES)
                  && (d.exec_states <= `SEQ_MAX_STATES);                              // [RULE3]
    endfunction : desc_legal

    // ----------------------------------------------------------------
    // Master clock: one state per half oscillator period
    // ----------------------------------------------------------------
    // Both oscillator edges give a state, so states come at twice its rate
    logic osc_meta;
    logic osc_sync;
    logic osc_last;
    logic ext_meta;
    logic ext_sync;
    logic next_master_clock;
    logic tick;

    always_comb
    begin
        tick              = osc_sync ^ osc_last;  // [RULE1]
        next_master_clock = tick;  // [RULE1]
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            osc_meta     <= 1'b0;
            osc_sync     <= 1'b0;
            osc_last     <= 1'b0;
            ext_meta     <= 1'b1;
            ext_sync     <= 1'b1;
        end
        else if (enable_i)
        begin
            osc_meta     <= osc_i;
            osc_sync     <= osc_meta;
            osc_last     <= osc_sync;
            ext_meta     <= external_program_select_pin_n_i;
            ext_sync     <= ext_meta;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    seq_pkg::seq_state_e state;
    seq_pkg::seq_state_e next_state;
    logic [5:0] count;
    logic [5:0] next_count;
    logic [2:0] bytes_left;
    logic [2:0] next_bytes_left;
    logic [1:0] wait_left;
    logic [1:0] next_wait_left;
    logic [5:0] exec_len;
    logic [5:0] next_exec_len;
    logic [5:0] states_used;
    logic [5:0] next_states_used;
    logic       external;
    logic       take;
    logic       done;
    logic       trap;
    logic       clr;
    logic       entry;
    logic       start;
    logic [4:0] irq_len;

    always_comb
    begin
        external         = ~ext_sync;
        irq_len          = extended_space_i ? `SEQ_IRQ_CYCLES_EXT : `SEQ_IRQ_CYCLES; // [RULE10] [RULE11]
        next_state       = state;
        next_count       = count;
        next_bytes_left  = bytes_left;
        next_wait_left   = wait_left;
        next_exec_len    = exec_len;
        next_states_used = states_used;
        take             = 1'b0;
        done             = 1'b0;
        trap             = 1'b0;
        clr              = 1'b0;
        entry            = 1'b0;
        start            = 1'b0;
        if (tick)  // [RULE2]
        begin
            unique case (state)
                seq_pkg::IDLE:
                begin
                    if (irq_request_i)
                    begin
                        next_state = seq_pkg::IRQ_ENTRY;
                        next_count = 6'h01;
                        entry      = 1'b1;
                    end
                    else if (instr_valid_i)
                    begin
                        take = 1'b1;
                        if (!desc_legal(instr_i))
                        begin
                            next_state = seq_pkg::TRAP;  // [RULE7]
                            trap       = 1'b1;
                        end
                        else
                        begin
                            next_bytes_left  = instr_length(instr_i);
                            next_exec_len    = instr_i.exec_states;
                            next_states_used = 6'h00;
                            next_state       = seq_pkg::FETCH;
                        end
                    end
                end
                seq_pkg::FETCH:
                begin
                    if (external)
                    begin
                        next_wait_left = program_fetch_wait_setting_i;  // [RULE9]
                        next_state     = seq_pkg::FETCH_WAIT;           // [RULE8]
                    end
                    else if (bytes_left == 3'h1)
                    begin
                        next_state = seq_pkg::EXECUTE;
                        next_count = 6'h01;
                    end
                    next_bytes_left = bytes_left - 3'h1;
                end
                seq_pkg::FETCH_WAIT:
                begin
                    // Programmed waits spent here first, then the fixed extra state
                    if (wait_left != 2'h0)
                    begin
                        next_wait_left = wait_left - 2'h1;  // [RULE9]
                    end
                    else if (bytes_left == 3'h0)
                    begin
                        next_state = seq_pkg::EXECUTE;
                        next_count = 6'h01;
                    end
                    else
                    begin
                        next_state = seq_pkg::FETCH;
                    end
                end
                seq_pkg::EXECUTE:
                begin
                    // Fetch states stall the core but are not counted as work
                    if (count >= exec_len)  // [RULE3]
                    begin
                        next_state = seq_pkg::IDLE;
                        done       = 1'b1;
                    end
                    else
                    begin
                        next_count = count + 6'h01;
                    end
                    next_states_used = count;
                end
                seq_pkg::IRQ_ENTRY:
                begin
                    clr = (count[4:0] == `SEQ_IRQ_CLEAR_CYCLE);  // [RULE12]
                    if (count[4:0] == irq_len)
                    begin
                        next_state = seq_pkg::IDLE;  // [RULE13]
                        start      = 1'b1;
                    end
                    else
                    begin
                        next_count = count + 6'h01;
                    end
                end
                seq_pkg::TRAP:
                begin
                    // Held until reset: only reset_i leaves the trap state
                    trap = 1'b1;
                end
                default:
                begin
                    next_state = seq_pkg::TRAP;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            state           <= seq_pkg::IDLE;
            count           <= 6'h00;
            bytes_left      <= 3'h0;
            wait_left       <= 2'h0;
            exec_len        <= 6'h00;
            states_used     <= 6'h00;
            master_clock_o  <= 1'b0;
            state_tick_o    <= 1'b0;
            instr_take_o    <= 1'b0;
            fetch_active_o  <= 1'b0;
            instr_done_o    <= 1'b0;
            opcode_trap_o   <= 1'b0;
            irq_clear_o     <= 1'b0;
            irq_entry_o     <= 1'b0;
            handler_start_o <= 1'b0;
            state_count_o   <= 6'h00;
        end
        else if (enable_i)
        begin
            state           <= next_state;
            count           <= next_count;
            bytes_left      <= next_bytes_left;
            wait_left       <= next_wait_left;
            exec_len        <= next_exec_len;
            states_used     <= next_states_used;
            master_clock_o  <= next_master_clock;
            state_tick_o    <= tick;
            instr_take_o    <= take;
            fetch_active_o  <= (next_state == seq_pkg::FETCH)
                            || (next_state == seq_pkg::FETCH_WAIT);
            instr_done_o    <= done;
            opcode_trap_o   <= trap || (next_state == seq_pkg::TRAP);
            irq_clear_o     <= clr;
            irq_entry_o     <= entry || start || (next_state == seq_pkg::IRQ_ENTRY);
            handler_start_o <= start;
            state_count_o   <= next_states_used;
        end
    end

endmodule : core_state_timing_sequencer

`default_nettype wire

// ### verif/seq_checker.sv
/*
 * Port checker for the core state sequencer, bound to its top module.
 * Assumes outputs are registered alongside state_tick_o.
 */
`timescale 1ns/1ns
`default_nettype none
`include "seq_defines.svh"

module seq_checker (
    input wire logic       clock_i,
    input wire logic       reset_i,
    input wire logic       extended_space_i,
    input wire logic       master_clock_o,
    input wire logic       state_tick_o,
    input wire logic       instr_take_o,
    input wire logic       fetch_active_o,
    input wire logic       instr_done_o,
    input wire logic       opcode_trap_o,
    input wire logic       irq_clear_o,
    input wire logic       irq_entry_o,
    input wire logic       handler_start_o,
    input wire logic [5:0] state_count_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);

    // ----------------------------------------------------------
    // Entry tick counter
    // ----------------------------------------------------------
    logic [4:0] ent_cnt;
    logic [4:0] next_ent_cnt;
    logic [4:0] ent_len;

    assign ent_len = extended_space_i ? `SEQ_IRQ_CYCLES_EXT : `SEQ_IRQ_CYCLES;

    always_comb
    begin
        next_ent_cnt = ent_cnt;
        if (!irq_entry_o)
            next_ent_cnt = 5'h00;
        else if (state_tick_o)
            next_ent_cnt = ent_cnt + 5'h01;
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            ent_cnt <= 5'h00;
        else
            ent_cnt <= next_ent_cnt;
    end

    sequence entry_start;
        $rose(irq_entry_o);
    endsequence

    sequence handler_end;
        handler_start_o && ent_cnt == ent_len;
    endsequence

    chk_master_toggle: assert property ($rose(master_clock_o) == state_tick_o)
        else $error("master clock not rising once per state");
    chk_tick_single: assert property (state_tick_o |=> !state_tick_o)
        else $error("state tick longer than one clock");
    chk_take_on_tick: assert property (instr_take_o |-> state_tick_o ##1 !instr_take_o)
        else $error("take pulse off a state boundary");
    chk_done_range: assert property (instr_done_o |->
        state_tick_o && state_count_o >= 6'h02 && state_count_o <= 6'h30)
        else $error("instruction state count out of range");
    chk_trap_latch: assert property (opcode_trap_o |=> opcode_trap_o)
        else $error("trap dropped before reset");
    chk_clear_third: assert property ((irq_entry_o && state_tick_o && ent_cnt == 5'h03)
        == irq_clear_o)
        else $error("request clear not in third entry cycle");
    chk_entry_length: assert property (entry_start |-> ##[1:300] handler_end)
        else $error("entry sequence length wrong");
    chk_handler_count: assert property (handler_start_o |-> irq_entry_o && ent_cnt == ent_len)
        else $error("handler start at wrong entry count");
    chk_no_early_fetch: assert property (irq_entry_o && ent_cnt <= ent_len |->
        !instr_take_o && !fetch_active_o)
        else $error("fetch during entry sequence");
endmodule : seq_checker

bind core_state_timing_sequencer seq_checker chk_u (
    .clock_i(clock_i), .reset_i(reset_i), .extended_space_i(extended_space_i),
    .master_clock_o(master_clock_o), .state_tick_o(state_tick_o),
    .instr_take_o(instr_take_o), .fetch_active_o(fetch_active_o),
    .instr_done_o(instr_done_o), .opcode_trap_o(opcode_trap_o), .irq_clear_o(irq_clear_o),
    .irq_entry_o(irq_entry_o), .handler_start_o(handler_start_o),
    .state_count_o(state_count_o));

`default_nettype wire

// ### verif/osc_model.sv
/*
 * Free-running oscillator feeding the sequencer.
 * Assumes HALF clocks per half period, at least four.
 */
`timescale 1ns/1ns
`default_nettype none

module osc_model #(
    parameter int HALF = 4
) (
    input  wire logic clock_i,
    output logic      osc_o
);
    int   cnt = 0;
    logic osc = 1'b0;

    assign osc_o = osc;

    // Runs free: a crystal never stops between instructions
    always @(posedge clock_i)
    begin
        if (cnt == HALF - 1)
        begin
            cnt <= 0;
            osc <= ~osc;
        end
        else
            cnt <= cnt + 1;
    end
endmodule : osc_model

`default_nettype wire

// ### verif/tb_top.sv
/*
 * Directed bench for the core state sequencer.
 * Assumes osc_model as oscillator and the bound checker.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    logic                 clock_i, reset_i, osc_i, ext_n, extsp, irq, valid;
    logic [1:0]           wait_set;
    seq_pkg::instr_desc_s desc;
    logic                 mclk, tick, take, fetch, done, trap, clr, entry, hstart;
    logic [5:0]           count;
    int                   err_count, num_checks;

    core_state_timing_sequencer dut_u (.clock_i(clock_i), .reset_i(reset_i),
        .enable_i(1'b1), .osc_i(osc_i), .external_program_select_pin_n_i(ext_n),
        .program_fetch_wait_setting_i(wait_set), .extended_space_i(extsp),
        .irq_request_i(irq), .instr_valid_i(valid), .instr_i(desc),
        .master_clock_o(mclk), .state_tick_o(tick), .instr_take_o(take),
        .fetch_active_o(fetch), .instr_done_o(done), .opcode_trap_o(trap),
        .irq_clear_o(clr), .irq_entry_o(entry), .handler_start_o(hstart),
        .state_count_o(count));
    osc_model #(.HALF(4)) osc_u (.clock_i(clock_i), .osc_o(osc_i));

    initial
    begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    function automatic seq_pkg::instr_desc_s mk(input logic p, input logic [1:0] a, o,
        input logic [2:0] s, input logic [5:0] e, input logic asg);
        mk = {p, a, o, s, asg, e};
    endfunction : mk

    task automatic chk_num(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask : chk_num

    task automatic chk_flag(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk_flag

    task automatic do_reset;
        @(negedge clock_i);
        reset_i = 1'b1;
        repeat (16) @(negedge clock_i);
        reset_i = 1'b0;
        repeat (4) @(negedge clock_i);
    endtask : do_reset

    // Counts every state from take to done, fetch states included
    task automatic run_instr(input seq_pkg::instr_desc_s d, input logic ext, input logic [1:0] w);
        int n, ticks, fticks, len, fexp;
        @(negedge clock_i);
        desc = d;
        valid = 1'b1;
        ext_n = ~ext;
        wait_set = w;
        for (n = 0; n < 400 && !take; n++) @(negedge clock_i);
        chk_flag(take, 1'b1);
        valid = 1'b0;
        ticks = 0;
        fticks = int'(fetch);
        for (n = 0; n < 2000 && !done; n++)
        begin
            @(negedge clock_i);
            ticks += int'(tick);
            fticks += int'(tick && fetch);
        end
        len = d.prefixed ? int'(d.addr_bytes) + int'(d.op_bytes) : int'(d.short_bytes);
        fexp = len * (ext ? 2 + int'(w) : 1);
        chk_num(8'(fticks), 8'(fexp));
        chk_num(8'(ticks), 8'(fexp + int'(d.exec_states)));
        chk_num({2'h0, count}, {2'h0, d.exec_states});
    endtask : run_instr

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_internal;
        run_instr(mk(1'b0, 2'h0, 2'h0, 3'h1, 6'h02, 1'b1), 1'b0, 2'h0);
        run_instr(mk(1'b0, 2'h0, 2'h0, 3'h4, 6'h30, 1'b1), 1'b0, 2'h0);
        run_instr(mk(1'b1, 2'h3, 2'h3, 3'h0, 6'h05, 1'b1), 1'b0, 2'h0);
        $display("t_internal done");
    endtask : t_internal

    task automatic t_external;
        run_instr(mk(1'b0, 2'h0, 2'h0, 3'h1, 6'h02, 1'b1), 1'b1, 2'h0);
        for (int w = 0; w < 4; w++)
            run_instr(mk(1'b1, 2'h1, 2'h2, 3'h0, 6'h03, 1'b1), 1'b1, 2'(w));
        $display("t_external done");
    endtask : t_external

    // Instruction waits during entry; it must not start before the handler
    task automatic t_irq(input logic x, input int len);
        int n, ticks, hits;
        @(negedge clock_i);
        extsp = x;
        irq = 1'b1;
        desc = mk(1'b0, 2'h0, 2'h0, 3'h2, 6'h02, 1'b1);
        valid = 1'b1;
        for (n = 0; n < 400 && !entry; n++) @(negedge clock_i);
        chk_flag(entry, 1'b1);
        ticks = 0;
        hits = 0;
        for (n = 0; n < 600 && !take; n++)
        begin
            @(negedge clock_i);
            ticks += int'(tick);
            if (clr)
            begin
                chk_num(8'(ticks), 8'h03);
                irq = 1'b0;
                hits++;
            end
            if (hstart)
            begin
                chk_num(8'(ticks), 8'(len));
                hits++;
            end
        end
        chk_num(8'(hits), 8'h02);
        chk_flag(ticks > len, 1'b1);
        valid = 1'b0;
        for (n = 0; n < 2000 && !done; n++) @(negedge clock_i);
        chk_flag(done, 1'b1);
        $display("t_irq done");
    endtask : t_irq

    // Window of 64 clocks holds whole oscillator periods at any phase
    task automatic t_clock;
        int   rises, periods;
        logic m_prev, o_prev;
        rises = 0;
        periods = 0;
        @(negedge clock_i);
        m_prev = mclk;
        o_prev = osc_i;
        repeat (64)
        begin
            @(negedge clock_i);
            rises += int'(mclk && !m_prev);
            periods += int'(osc_i && !o_prev);
            m_prev = mclk;
            o_prev = osc_i;
        end
        chk_num(8'(rises), 8'(2 * periods));
        chk_flag(periods > 0, 1'b1);
        $display("t_clock done");
    endtask : t_clock

    task automatic t_trap;
        for (int i = 0; i < 2; i++)
        begin
            @(negedge clock_i);
            desc = i ? mk(1'b0, 2'h0, 2'h0, 3'h2, 6'h31, 1'b1) : mk(1'b0, 2'h0, 2'h0, 3'h2, 6'h04, 1'b0);
            valid = 1'b1;
            for (int n = 0; n < 400 && !trap; n++) @(negedge clock_i);
            chk_flag(trap, 1'b1);
            valid = 1'b0;
            repeat (40) @(negedge clock_i);
            chk_flag(trap, 1'b1);
            do_reset();
            chk_flag(trap, 1'b0);
        end
        $display("t_trap done");
    endtask : t_trap

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    initial
    begin
        {reset_i, ext_n, extsp, irq, valid, wait_set} = 7'h60;
        desc = '0;
        err_count = 0;
        num_checks = 0;
        do_reset();
        t_clock();
        t_internal();
        t_external();
        t_irq(1'b0, 14);
        t_irq(1'b1, 17);
        t_trap();
        results();
    end

    initial
    begin
        #400000;
        err_count++;
        $display("CHECK FAILED %0t: watchdog expired", $time);
        results();
    end
endmodule : tb_top

`default_nettype wire
